//--- hw/sfcr_dev.sv
// Device end: opcode decode, address capture and streaming read of the main array.
// Assumes the host runs mode 0 or 3 and a preload port fills the array while idle.
//
// How it works
// R1: Works with serial clock modes 0 and 3
// R2: Select falls, opcode then address, MSB first
// R3: Input sampled on rising edge, ignored deselected
// R4: Output bits shift on falling clock edge
// R5: Legacy read: address then four dummy bytes
// R6: Fastest read: address then two dummy bytes
// R7: Fast read: address then one dummy byte
// R8: Slow read: data right after address
// R9: Standard pages: 12 page, 9 byte bits
// R10: Binary pages: 20 bits, 12 page, 8 byte
// R11: Internal counter advances, no further address
// R12: Page end rolls to next page, no gap
// R13: Array end wraps to first page, no gap
// R14: Host holds select low whole read
// R15: Select rising ends read, releases output
// R16: Reads never touch the SRAM buffers
// R17: Host keeps clock under per-opcode limit
// R18: Host prefers non-legacy continuous read opcodes
// R19: Dummy byte values are ignored
`timescale 1ns/100ps
module sfcr_dev
  import sfcr_pkg::*;
(
  // Link to host
  sfcr_link_if.dev link,
  // System clock and reset for preload and status
  input wire logic clk,
  input wire logic resetn,
  // Page size strap, high for binary pages
  input wire logic page_256,
  // Array preload
  input wire logic load_en,
  input wire logic [20:0] load_addr,
  input wire logic [7:0] load_data,
  // Status in system clock domain
  output logic read_active
);

  // Main array storage; no SRAM buffer exists on this path
  logic [7:0] mem [SFCR_MEM_BYTES]; // R16

  // Link domain state
  sfcr_phase_e phase_q;
  sfcr_phase_e phase_d;
  logic [2:0] bit_q;
  logic [6:0] in_sr_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] dummy_q;
  logic [15:0] addr_q;
  logic [11:0] page_q;
  logic [8:0] byte_q;
  logic [11:0] page_d;
  logic [8:0] byte_d;
  logic cfg_meta_q;
  logic cfg_q;
  logic so_q;
  logic so_oe_q;
  logic act_link_q;
  // System domain state
  logic act_meta_q;
  logic act_q;

  // Byte assembly and decode
  wire [7:0] in_byte = {in_sr_q, link.mosi}; // R2
  wire byte_done = bit_q == SFCR_BIT_LAST;
  wire [3:0] op_info = sfcr_op_decode(in_byte);
  wire op_known = op_info[3];
  wire [2:0] op_dummy = op_info[2:0];
  wire [23:0] addr_full = {addr_q, in_byte};
  wire addr_last = cnt_q == SFCR_ADDR_LAST;
  wire dummy_last = cnt_q == (dummy_q - 3'h1);

  // Start address split by page size
  wire [11:0] page_load = cfg_q ? addr_full[19:8] : addr_full[20:9]; // R10 R9
  wire [8:0] byte_load = cfg_q ? {1'b0, addr_full[7:0]} : addr_full[8:0]; // R10 R9

  // Counter step; page number wraps on its own at the array end
  wire [8:0] last_byte = cfg_q ? SFCR_LAST_BYTE_BIN : SFCR_LAST_BYTE_STD;
  wire page_end = byte_q >= last_byte;
  wire [11:0] page_inc = page_end ? page_q + 12'h001 : page_q; // R12 R13
  wire [8:0] byte_inc = page_end ? 9'h000 : byte_q + 9'h001; // R12

  // Array index; binary pages leave the top eight bytes unused
  wire [20:0] page_base = {1'b0, page_q, 8'h00} + {6'h00, page_q, 3'h0};
  wire [20:0] rd_idx = page_base + {12'h000, byte_q};
  wire [7:0] rd_byte = mem[rd_idx];

  // Phase sequencing; acts only on a completed byte
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    if (byte_done) begin
      case (phase_q)
        PH_OPCODE: begin
          phase_d = op_known ? PH_ADDR : PH_IGNORE;
          cnt_d = 3'h0;
        end
        PH_ADDR: begin
          cnt_d = cnt_q + 3'h1;
          if (addr_last) begin
            phase_d = (dummy_q == 3'h0) ? PH_DATA : PH_DUMMY; // R8
            cnt_d = 3'h0;
          end
        end
        PH_DUMMY: begin // R19
          cnt_d = cnt_q + 3'h1;
          if (dummy_last) begin
            phase_d = PH_DATA; // R5 R6 R7
          end
        end
        PH_DATA: phase_d = PH_DATA;
        PH_IGNORE: phase_d = PH_IGNORE;
        default: phase_d = PH_IGNORE;
      endcase
    end
  end

  // Address counter next value
  always_comb begin
    page_d = page_q;
    byte_d = byte_q;
    if (byte_done && phase_q == PH_ADDR && addr_last) begin
      page_d = page_load;
      byte_d = byte_load;
    end else if (byte_done && phase_q == PH_DATA) begin
      page_d = page_inc; // R11
      byte_d = byte_inc; // R11
    end
  end

  // Select high acts as async clear, since the serial clock stops between frames
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      phase_q <= PH_OPCODE; // R15
      bit_q <= 3'h0;
      cnt_q <= 3'h0;
    end else begin
      phase_q <= phase_d;
      bit_q <= bit_q + 3'h1; // R3
      cnt_q <= cnt_d;
    end
  end

  // Input shift and captured fields; dummy contents never stored
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      in_sr_q <= 7'h00;
      dummy_q <= 3'h0;
      addr_q <= 16'h0000;
    end else begin
      in_sr_q <= in_byte[6:0]; // R3
      if (byte_done && phase_q == PH_OPCODE) begin
        dummy_q <= op_dummy; // R5 R6 R7 R8
      end
      if (phase_q == PH_ADDR && byte_done) begin
        addr_q <= addr_full[15:0]; // R19
      end
    end
  end

  // Live address counter
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      page_q <= 12'h000;
      byte_q <= 9'h000;
    end else begin
      page_q <= page_d;
      byte_q <= byte_d;
    end
  end

  // Page size strap into the link domain
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cfg_meta_q <= 1'b0;
      cfg_q <= 1'b0;
    end else begin
      cfg_meta_q <= page_256;
      cfg_q <= cfg_meta_q;
    end
  end

  // Output on falling edge so the host has a full half period to sample
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0; // R15
      act_link_q <= 1'b0;
    end else begin
      so_q <= rd_byte[~bit_q]; // R4 R1
      so_oe_q <= phase_q == PH_DATA; // R4
      act_link_q <= phase_q == PH_DATA;
    end
  end

  assign link.miso = so_q;
  assign link.miso_oe = so_oe_q;

  // Preload port; expected only while no read is running
  always_ff @(posedge clk) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // Read activity level into the system domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_meta_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      act_meta_q <= act_link_q;
      act_q <= act_meta_q;
    end
  end

  assign read_active = act_q;

endmodule // sfcr_dev

//--- hw/sfcr_host.sv
// Host end: issues one continuous read per request and drains data through a small FIFO.
// Assumes a device on the link interface; the serial clock is divided from clk.
`timescale 1ns/100ps
module sfcr_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] buf_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;

  // Depth is a power of two so pointers wrap naturally
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = buf_q[rp_q];

  always_ff @(posedge clk) begin
    if (push) begin
      buf_q[wp_q] <= in_data;
    end
  end

  // Pointer and fill count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sfcr_fifo

module sfcr_host
  import sfcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Read request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_opcode,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_len,
  // Read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Link to device
  sfcr_link_if.host link
);
  typedef enum logic {ST_IDLE, ST_SHIFT} sfcr_hst_e;

  sfcr_hst_e st_q;
  logic [3:0] div_q;
  logic sck_q;
  logic cs_n_q;
  logic mosi_q;
  logic [63:0] tx_q;
  logic [7:0] rx_q;
  logic [19:0] bits_q;
  logic [19:0] total_q;
  logic [19:0] rx_start_q;
  logic push_q;
  logic miso_meta_q;
  logic miso_s_q;
  logic fifo_ready;

  // Request decode; unknown opcodes are sent with no dummy bytes
  wire [3:0] op_info = sfcr_op_decode(req_opcode);
  // Header byte count needs four bits: the legacy read has eight header bytes
  wire [3:0] hdr_bytes = {1'b0, SFCR_HDR_BYTES} + {1'b0, op_info[2:0]};
  wire [19:0] hdr_bits = {13'h0000, hdr_bytes, 3'h0}; // R5 R6 R7 R8
  wire take = req_valid && st_q == ST_IDLE;
  // Clock pauses while a byte waits for FIFO room, so back-pressure reaches the link
  wire stall = push_q;
  wire tick = st_q == ST_SHIFT && div_q == SFCR_SCK_HALF - 4'h1 && !stall; // R17
  wire rise = tick && !sck_q;
  wire fall = tick && sck_q;
  wire in_rx = bits_q >= rx_start_q;
  wire rx_byte_end = rise && in_rx && bits_q[2:0] == 3'h7;
  wire frame_end = fall && bits_q == total_q;

  // Divider for the serial clock
  always_ff @(posedge clk) begin
    if (!resetn || st_q == ST_IDLE || tick) begin
      div_q <= 4'h0;
    end else if (div_q != SFCR_SCK_HALF - 4'h1) begin
      div_q <= div_q + 4'h1;
    end
  end

  // Frame control; clock idles low, which is mode 0
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0; // R1
    end else if (take) begin
      st_q <= ST_SHIFT;
      cs_n_q <= 1'b0; // R2
    end else if (frame_end) begin
      st_q <= ST_IDLE;
      cs_n_q <= 1'b1; // R14
      sck_q <= 1'b0;
    end else if (tick) begin
      sck_q <= !sck_q;
    end
  end

  // Transmit shifter, MSB first, dummies sent as zero; data changes while clock is low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_q <= 64'h0;
      mosi_q <= 1'b0;
    end else if (take) begin
      tx_q <= {req_opcode, req_addr, 32'h0}; // R2
      mosi_q <= req_opcode[7];
    end else if (fall) begin
      tx_q <= {tx_q[62:0], 1'b0};
      mosi_q <= tx_q[62]; // R2
    end
  end

  // Bit accounting for the whole frame
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bits_q <= 20'h0;
      total_q <= 20'h0;
      rx_start_q <= 20'h0;
    end else if (take) begin
      bits_q <= 20'h0;
      total_q <= hdr_bits + {1'b0, req_len, 3'h0};
      rx_start_q <= hdr_bits;
    end else if (rise) begin
      bits_q <= bits_q + 20'h1;
    end
  end

  // Sampled data; synchroniser output lags the pin by two cycles, well inside a half period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      miso_meta_q <= 1'b0;
      miso_s_q <= 1'b0;
      rx_q <= 8'h00;
      push_q <= 1'b0;
    end else begin
      miso_meta_q <= link.so_line;
      miso_s_q <= miso_meta_q;
      rx_q <= (rise && in_rx) ? {rx_q[6:0], miso_s_q} : rx_q;
      push_q <= rx_byte_end || (push_q && !fifo_ready);
    end
  end

  assign req_ready = st_q == ST_IDLE;
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.mosi = mosi_q;

  // Received bytes wait here for the consumer
  sfcr_fifo #(.W(8), .D(4)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(rx_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule // sfcr_host

//--- hw/sfcr_link_if.sv
// Serial link between host controller and flash read front end.
// Assumes the bench joins the two ends through this interface only.
`timescale 1ns/100ps
interface sfcr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  wire so_line;

  // Released line shows the inverse of the last bit, so a stray sample miscompares
  assign so_line = miso_oe ? miso : ~miso;

  modport host (output cs_n, output sck, output mosi, input so_line);
  modport dev (input cs_n, input sck, input mosi, output miso, output miso_oe);
endinterface

//--- hw/sfcr_pkg.sv
// Shared constants, types and opcode decoding for the serial flash continuous read link.
// Assumes both ends import it whole; no clocks or processes live here.
package sfcr_pkg;

  // Continuous main-array read opcodes
  localparam logic [7:0] SFCR_OP_LEGACY = 8'he8;
  localparam logic [7:0] SFCR_OP_TOP = 8'h1b;
  localparam logic [7:0] SFCR_OP_MID = 8'h0b;
  localparam logic [7:0] SFCR_OP_LOW = 8'h03;

  // Dummy byte counts per opcode
  localparam logic [2:0] SFCR_DUMMY_LEGACY = 3'h4;
  localparam logic [2:0] SFCR_DUMMY_TOP = 3'h2;
  localparam logic [2:0] SFCR_DUMMY_MID = 3'h1;
  localparam logic [2:0] SFCR_DUMMY_LOW = 3'h0;

  // Frame layout
  localparam logic [2:0] SFCR_BIT_LAST = 3'h7;
  localparam logic [2:0] SFCR_ADDR_LAST = 3'h2;
  localparam logic [2:0] SFCR_HDR_BYTES = 3'h4;

  // Array geometry
  localparam int SFCR_PAGES = 4096;
  localparam int SFCR_PAGE_STD = 264;
  localparam int SFCR_MEM_BYTES = SFCR_PAGES * SFCR_PAGE_STD;
  localparam logic [8:0] SFCR_LAST_BYTE_STD = 9'h107;
  localparam logic [8:0] SFCR_LAST_BYTE_BIN = 9'h0ff;

  // Host serial clock timing
  localparam int SFCR_CLK_NS = 5;
  localparam int SFCR_SCK_HALF_NS = 20;
  localparam logic [3:0] SFCR_SCK_HALF = 4'(SFCR_SCK_HALF_NS / SFCR_CLK_NS);

  // Device receive phases
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} sfcr_phase_e;

  // Returns {known, dummy byte count}; both ends decode the same way
  function automatic logic [3:0] sfcr_op_decode(input logic [7:0] op);
    logic [3:0] r;
    r = 4'h0;
    case (op)
      SFCR_OP_LEGACY: r = {1'b1, SFCR_DUMMY_LEGACY};
      SFCR_OP_TOP: r = {1'b1, SFCR_DUMMY_TOP};
      SFCR_OP_MID: r = {1'b1, SFCR_DUMMY_MID};
      SFCR_OP_LOW: r = {1'b1, SFCR_DUMMY_LOW};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

endpackage

//--- sim/sfcr_link_sva.sv
// Link checker for the serial flash read link, watching the interface wires.
// Assumes the host runs mode 0 with a four-clock half period of the serial clock.
`timescale 1ns/100ps
module sfcr_link_sva (
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [15:0] rise_cnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Serial clock rises since select fell; cleared between frames
  always_ff @(posedge clk) begin
    if (!resetn || cs_n) begin
      rise_cnt_q <= 16'h0;
    end else if ($rose(sck)) begin
      rise_cnt_q <= rise_cnt_q + 16'h1;
    end
  end

  // High half of the serial clock is the host's full divide
  sequence s_sck_high;
    sck [*4];
  endsequence

  chk_sck_half: assert property ($rose(sck) |-> s_sck_high)
    else $error("serial clock high phase too short");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("serial clock not idle low while deselected");
  chk_cs_fall: assert property ($fell(cs_n) |-> !sck && !miso_oe && rise_cnt_q == 16'h0)
    else $error("frame start not clean");
  chk_mosi_rise: assert property ($rose(sck) |-> $stable(mosi))
    else $error("host data moved at sampling edge");
  chk_miso_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> $fell(sck))
    else $error("device data moved off falling edge");
  chk_hdr_len: assert property ($rose(miso_oe) |-> $fell(sck) && (rise_cnt_q == 16'd32 ||
    rise_cnt_q == 16'd40 || rise_cnt_q == 16'd48 || rise_cnt_q == 16'd64))
    else $error("data began after wrong header length");
  chk_byte_frame: assert property ($rose(cs_n) |-> rise_cnt_q[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  chk_oe_release: assert property (cs_n |-> !miso_oe)
    else $error("output driven while deselected");
  chk_oe_cause: assert property ($fell(miso_oe) |-> cs_n)
    else $error("output released without deselect");
endmodule // sfcr_link_sva

//--- sim/test_serial_flash_continuous_read.sv
// Self-checking bench joining host and device ends of the read link.
// Assumes the array is preloaded through the device load port while idle.
`timescale 1ns/100ps
module test_serial_flash_continuous_read;
  import sfcr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_opcode = 8'h0;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_len = 16'h0;
  logic rd_ready = 1'b0;
  logic page_256 = 1'b0;
  logic load_en = 1'b0;
  logic [20:0] load_addr = 21'h0;
  logic [7:0] load_data = 8'h0;
  logic req_ready, rd_valid, read_active, oe_seen, act_seen;
  logic [7:0] rd_data;
  logic [7:0] ops [4] = '{SFCR_OP_LEGACY, SFCR_OP_TOP, SFCR_OP_MID, SFCR_OP_LOW};
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  integer seed;

  sfcr_link_if link ();
  sfcr_host i_sfcr_host (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_opcode(req_opcode), .req_addr(req_addr), .req_len(req_len), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .link(link.host));
  sfcr_dev i_sfcr_dev (.link(link.dev), .clk(clk), .resetn(resetn), .page_256(page_256), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .read_active(read_active));
  sfcr_link_sva i_sfcr_link_sva (.clk(clk), .resetn(resetn), .cs_n(link.cs_n), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  // Hang guard and output-enable watch
  always @(posedge clk) begin
    cycles++;
    if (link.miso_oe === 1'b1) oe_seen <= 1'b1;
    if (read_active === 1'b1) act_seen <= 1'b1;
    if (cycles == 40000) begin
      bad("timeout");
      end_of_test();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic bad(input string msg);
    err_total++;
    $display("BAD at %0t: %s", $time, msg);
  endtask

  // Array index of the k-th streamed byte; page size decides the rollover
  function automatic int at_idx(input int p, input int b, input int k);
    int psz;
    int lin;
    psz = page_256 ? 256 : 264;
    lin = (p * psz + b + k) % (SFCR_PAGES * psz);
    return (lin / psz) * 264 + lin % psz;
  endfunction

  // Preload, request, then drain with a random or stalled reader
  task automatic do_read(input logic [7:0] op, input int p, input int b, input int len, input int stall);
    logic [7:0] exp_q [$];
    int got;
    int n;
    for (int k = 0; k < len; k++) begin
      load_en = 1'b1;
      load_addr = 21'(at_idx(p, b, k));
      load_data = 8'($random(seed));
      exp_q.push_back(load_data);
      tick();
    end
    load_en = 1'b0;
    act_seen = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    req_valid = 1'b1;
    req_opcode = op;
    req_addr = page_256 ? {4'h0, 12'(p), 8'(b)} : {3'h0, 12'(p), 9'(b)};
    req_len = 16'(len);
    tick();
    req_valid = 1'b0;
    got = 0;
    n = 0;
    // Ready and settled valid both stand for the coming edge, where the pop happens
    while (got < len) begin
      rd_ready = (n >= stall) && ($random(seed) % 4 != 0);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        cmp_count++;
        if (rd_data !== exp_q[got]) bad("read byte differs");
        got++;
      end
      tick();
      n++;
    end
    while (req_ready !== 1'b1) tick();
    rd_ready = 1'b0;
    cmp_count++;
    if (link.cs_n !== 1'b1 || link.miso_oe !== 1'b0) bad("link not released");
    // Activity flag lags the link by two clocks through its synchroniser
    repeat (3) tick();
    cmp_count++;
    if (read_active !== 1'b0 || act_seen !== 1'(len > 0)) bad("read activity flag wrong");
    $display("Read op %h page %0d byte %0d len %0d done", op, p, b, len);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: every opcode, page and array rollover, both page sizes, a stall
  initial begin
    seed = 32'h5236;
    oe_seen = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    foreach (ops[i]) do_read(ops[i], {$random(seed)} % 4096, {$random(seed)} % 264, 3, 0);
    do_read(SFCR_OP_MID, 5, 262, 4, 0);
    do_read(SFCR_OP_TOP, 4095, 262, 3, 0);
    page_256 = 1'b1;
    do_read(SFCR_OP_LOW, 7, 254, 4, 0);
    do_read(SFCR_OP_LEGACY, 4095, 255, 2, 0);
    // Random traffic keeps to the non-legacy opcodes; legacy stays in the hand cases
    repeat (3) do_read(ops[1 + {$random(seed)} % 3], {$random(seed)} % 4096, {$random(seed)} % 256, 5, 0);
    page_256 = 1'b0;
    do_read(SFCR_OP_MID, {$random(seed)} % 4096, 263, 8, 700);
    oe_seen = 1'b0;
    do_read(8'h5a, 3, 0, 0, 0);
    cmp_count++;
    if (oe_seen !== 1'b0) bad("unknown opcode drove output");
    end_of_test();
  end
endmodule // test_serial_flash_continuous_read
